// [src/mgmt_mode_defs.vh]
// Constants for the management port mode selector.
// Assumes inclusion by bare name from the design files.
`ifndef MGMT_MODE_DEFS_VH
`define MGMT_MODE_DEFS_VH
// ==========================================
// Access modes, {bus_select_hi, bus_select_lo}
`define MODE_EEPROM_MASTER 2'h0
`define MODE_I2C_SLAVE     2'h1
`define MODE_SPI_SLAVE     2'h2
`define MODE_FULL_MGMT     2'h3
// ==========================================
// I2C slave address bytes
`define I2C_ADDR_READ      8'hbf
`define I2C_ADDR_WRITE     8'hbe
`define I2C_ADDR_MASK      8'hfe
// ==========================================
// Strap capture settle count after reset release
`define STRAP_SETTLE       4'h3
`endif

// [src/pin_sync.v]
// Two-flop synchroniser for one pin-side level.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ps
module pin_sync (
  // Clock and reset
  input  wire clk,
  input  wire srst,
  // Level in and out
  input  wire din,
  output wire dout
);
  reg meta_q;  // First stage, read only by second stage
  reg sync_q;  // Second stage, safe to use
  // ==========================================
  // Synchroniser stages
  always @(posedge clk) begin
    if (srst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end
  assign dout = sync_q;
endmodule

// [src/management_port_mode_select.v]
// Management port mode selector: routes the shared serial pins.
// Assumes clk free runs, srst synchronous; protocol engines are outside.
`timescale 1ns/1ps
`include "mgmt_mode_defs.vh"
// ==========================================
// Design notes
// The strap synchronisers clear with srst, so the captured strap level
// is the one seen in the first few cycles after release. Boards must hold
// the strap levels for at least the settle window after reset ends.
// Mode is frozen once locked_q rises; a new mode needs a fresh srst.
// All pin drives are registered, so every output lags its source by
// one clock; pin inputs lag by two more for the synchroniser.
// Engine inputs come from logic on clk and so pass no synchroniser.
// The data line is open drain: sda_o stays low and only sda_oe moves.
// The link clock is never retimed here, only sampled, so it must run
// well below clk; the sampled copy goes to the slave engines.
// The select edge finder starts from the deselected level so that a
// false transfer start cannot follow reset.
// Mode 11 leaves every serial pin released; MDC/MDIO carry the access.
// Trade-off: the fixed settle count keeps the lock logic tiny, at the
// price of a short window in which strap noise could still be seen.
// Limitation: no protocol checking beyond the I2C address compare is done in this block;
// it steers pins, decodes the address and select fall, and flags which engine owns them.
// ==========================================
// Summary of operation
// - Straps 00: I2C master, drive clock
// - No EEPROM: use defaults plus straps
// - I2C slave answers 0xbf read, 0xbe write
// - Straps 10: SPI slave pin mapping
// - Straps 11: full register space via MDC/MDIO
// - Otherwise MDC/MDIO reach only PHY registers
// - Dual pins sampled just after reset release, outputs once locked
// - Select high tri-states output; fall starts transfer
// - Two straps choose the access mode
module management_port_mode_select (
  // Clock and reset
  input  wire       clk,
  input  wire       srst,
  // Strap pins
  input  wire       bus_select_hi,
  input  wire       bus_select_lo,
  // Serial clock pin
  input  wire       scl_i,
  output reg        scl_o,
  output reg        scl_oe,
  // Serial data pin
  input  wire       sda_i,
  output reg        sda_o,
  output reg        sda_oe,
  // SPI output and select
  output reg        serial_data_out,
  output reg        serial_data_out_oe,
  input  wire       serial_chip_select_n,
  // Dual-purpose strap/output pin
  input  wire       dual_pin_i,
  output reg        dual_pin_o,
  output reg        dual_pin_oe,
  input  wire       dual_func_out,
  output reg        dual_strap,
  // I2C master engine side
  input  wire       eeprom_scl,
  input  wire       eeprom_sda_drive_low,
  input  wire       eeprom_absent,
  output reg        use_reset_defaults,
  // Slave engines side
  input  wire       slave_sda_drive_low,
  input  wire       spi_dout,
  input  wire [7:0] addr_byte,
  input  wire       addr_valid,
  output reg        addr_match,
  output reg        addr_is_read,
  output reg        spi_start,
  output reg        spi_active,
  output reg        serial_clk_in,
  output reg        serial_data_in,
  // Management path steering
  output reg        full_register_mgmt_access,
  output reg        phy_only_mgmt_access,
  output reg  [1:0] mode
);
  // ==========================================
  // Synchronised pins
  wire hi_s, lo_s, scl_s, sda_s, cs_s, dual_s;
  genvar g;
  wire [5:0] raw  = {bus_select_hi, bus_select_lo, scl_i, sda_i, serial_chip_select_n, dual_pin_i};
  wire [5:0] sync;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_sync
      pin_sync u_sync (
        .clk  (clk),
        .srst (srst),
        .din  (raw[g]),
        .dout (sync[g])
      );
    end
  endgenerate
  assign {hi_s, lo_s, scl_s, sda_s, cs_s, dual_s} = sync;

  reg [1:0] mode_q;     // Latched access mode
  reg       dual_q;     // Latched dual pin strap
  reg       cs_prev_q;  // Select history for edge find
  reg [3:0] settle_q;   // Waits for synchronisers to fill
  reg       locked_q;   // Straps captured
  // ==========================================
  // Strap capture: synchronisers clear in reset, so the value sampled just after
  // release is held, frozen a few cycles later once the synchronisers have filled.
  always @(posedge clk) begin
    if (srst) begin
      settle_q <= 4'h0;
      locked_q <= 1'b0;
      mode_q   <= `MODE_EEPROM_MASTER;
      dual_q   <= 1'b0;
    end else if (!locked_q) begin
      settle_q <= settle_q + 4'h1;
      mode_q   <= {hi_s, lo_s};
      dual_q   <= dual_s;
      if (settle_q == `STRAP_SETTLE)
        locked_q <= 1'b1;
    end
  end
  // ==========================================
  // Pin routing per mode, registered outputs
  always @(posedge clk) begin
    if (srst) begin
      // All pins released while straps are sampled
      scl_o                     <= 1'b0;
      scl_oe                    <= 1'b0;
      sda_o                     <= 1'b0;
      sda_oe                    <= 1'b0;
      serial_data_out           <= 1'b0;
      serial_data_out_oe        <= 1'b0;
      dual_pin_o                <= 1'b0;
      dual_pin_oe               <= 1'b0;
      dual_strap                <= 1'b0;
      // Engine flags quiet
      use_reset_defaults        <= 1'b0;
      addr_match                <= 1'b0;
      addr_is_read              <= 1'b0;
      spi_start                 <= 1'b0;
      spi_active                <= 1'b0;
      serial_clk_in             <= 1'b0;
      serial_data_in            <= 1'b0;
      // No management path until the mode is known
      full_register_mgmt_access <= 1'b0;
      phy_only_mgmt_access      <= 1'b0;
      mode                      <= `MODE_EEPROM_MASTER;
      // Deselected level, so no false start after reset
      cs_prev_q                 <= 1'b1;
    end else begin
      cs_prev_q  <= cs_s;
      mode       <= mode_q;
      dual_strap <= dual_q;
      // Hold the dual pin as input until straps are frozen
      dual_pin_oe <= locked_q;
      dual_pin_o  <= locked_q & dual_func_out;
      full_register_mgmt_access <= locked_q & (mode_q == `MODE_FULL_MGMT);
      phy_only_mgmt_access      <= locked_q & (mode_q != `MODE_FULL_MGMT);
      serial_clk_in  <= scl_s;
      serial_data_in <= sda_s;
      // Defaults; open-drain data only ever drives low
      scl_o              <= 1'b0;
      scl_oe             <= 1'b0;
      sda_o              <= 1'b0;
      sda_oe             <= 1'b0;
      // SPI output released unless selected
      serial_data_out    <= 1'b0;
      serial_data_out_oe <= 1'b0;
      // Pulses and levels fall back each cycle
      use_reset_defaults <= 1'b0;
      addr_match         <= 1'b0;
      addr_is_read       <= 1'b0;
      spi_start          <= 1'b0;
      spi_active         <= 1'b0;
      if (locked_q) begin
        case (mode_q)
          `MODE_EEPROM_MASTER: begin
            scl_o  <= eeprom_scl;
            scl_oe <= 1'b1;
            sda_oe <= eeprom_sda_drive_low;
            use_reset_defaults <= eeprom_absent;
          end
          `MODE_I2C_SLAVE: begin
            // Clock pin left undriven, master owns it
            sda_oe <= slave_sda_drive_low;
            if (addr_valid) begin
              addr_match   <= (addr_byte & `I2C_ADDR_MASK) == `I2C_ADDR_WRITE;
              addr_is_read <= (addr_byte == `I2C_ADDR_READ);
            end
          end
          `MODE_SPI_SLAVE: begin
            spi_active         <= ~cs_s;
            spi_start          <= cs_prev_q & ~cs_s;
            serial_data_out    <= spi_dout;
            serial_data_out_oe <= ~cs_s;
          end
          `MODE_FULL_MGMT: begin
            // Serial pins idle; access goes over MDC/MDIO
          end
          default: begin
          end
        endcase
      end
    end
  end
endmodule

// [testbench/mode_sel_monitor.sv]
// Port checker for the management port mode selector.
// Assumes it is bound onto the selector top, one clock domain.
`timescale 1ns/1ps
module mode_sel_monitor (
  input wire       clk, srst, scl_oe, serial_data_out_oe, addr_match, addr_is_read, addr_valid,
  input wire       spi_start, spi_active, full_register_mgmt_access, phy_only_mgmt_access,
  input wire       dual_pin_oe, use_reset_defaults, eeprom_absent,
  input wire [7:0] addr_byte,
  input wire [1:0] mode
);
  // ====================
  // Cycles since release; mode counts as locked well past the settle window
  reg [3:0] up_q;
  always @(posedge clk) up_q <= srst ? 4'h0 : up_q + {3'h0, up_q != 4'hf};
  wire live = up_q > 4'h9;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  mode_hold_a: assert property (live |-> $stable(mode)) else $error("mode moved");
  scl_drive_a: assert property (scl_oe |-> mode == 2'h0) else $error("clock driven");
  serial_data_out_off_a: assert property (serial_data_out_oe |-> mode == 2'h2 && spi_active) else $error("spi out");
  full_path_a: assert property (live |-> full_register_mgmt_access == (mode == 2'h3)) else $error("full");
  phy_path_a: assert property (live |-> phy_only_mgmt_access != full_register_mgmt_access) else $error("phy");
  addr_hit_a: assert property (addr_match |-> $past(addr_valid) && ($past(addr_byte) | 8'h01) == 8'hbf
    && mode == 2'h1) else $error("addr");
  addr_read_a: assert property (addr_is_read |-> $past(addr_byte) == 8'hbf) else $error("read");
  start_once_a: assert property (spi_start |=> !spi_start) else $error("start");
  strap_out_a: assert property (live |-> dual_pin_oe) else $error("dual pin");
  no_eeprom_a: assert property (live && mode == 2'h0 |-> use_reset_defaults == $past(eeprom_absent))
    else $error("defaults");
  cover property (addr_match);
  cover property (spi_start);
  cover property (live && use_reset_defaults);
endmodule
bind management_port_mode_select mode_sel_monitor mode_sel_monitor_inst (.*);

// [testbench/host_model.sv]
// Far side: link clock and open-drain data line with pull-up.
// Assumes the bench raises frame around each transfer.
`timescale 1ns/1ps
module host_model (
  input  wire frame,
  input  wire sda_oe,
  output reg  scl,
  output wire sda
);
  // Clock toggles only within frames, 48 ns period, idles high
  initial scl = 1'b1;
  always #24 scl = frame ? ~scl : 1'b1;
  // Released line floats to the pull-up level
  assign sda = sda_oe ? 1'b0 : 1'b1;
endmodule

// [testbench/management_port_mode_select_tb.sv]
// Bench for the mode selector: every strap mode, random engine traffic.
// Assumes the host model and bound checker.
`timescale 1ns/1ps
module management_port_mode_select_tb;
  reg clk, srst, bus_select_hi, bus_select_lo, serial_chip_select_n, dual_pin_i, dual_func_out, eeprom_scl;
  reg eeprom_sda_drive_low, eeprom_absent, slave_sda_drive_low, spi_dout, addr_valid, frame, dexp;
  reg [7:0] addr_byte;
  reg [2:0] m;
  wire scl_i, sda_i, scl_o, scl_oe, sda_o, sda_oe, serial_data_out, serial_data_out_oe, dual_pin_o, dual_pin_oe;
  wire dual_strap, use_reset_defaults, addr_match, addr_is_read, spi_start, spi_active, serial_clk_in;
  wire serial_data_in, full_register_mgmt_access, phy_only_mgmt_access;
  wire [1:0] mode;
  integer bad_count = 0, tests_run = 0, i, hits = 0, base, seed;
  management_port_mode_select management_port_mode_select_inst (.*);
  host_model host_model_inst (.frame(frame), .sda_oe(sda_oe), .scl(scl_i), .sda(sda_i));
  // ====================
  // Pulse counter; each event pulses once, read as a difference
  always @(posedge clk) hits <= hits + addr_match + addr_is_read + spi_start;
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task tick(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  function f_sda(input [1:0] md, input e, input s);
    f_sda = md == 2'h0 ? e : md == 2'h1 ? s : 1'b0;
  endfunction
  // Expected pulses: match on either address, read on the read one, one start
  function [7:0] f_hits(input [1:0] md, input [7:0] ab);
    f_hits = {7'h0, md == 2'h1 && (ab | 8'h01) == 8'hbf} + {7'h0, md == 2'h1 && ab == 8'hbf}
      + {7'h0, md == 2'h2};
  endfunction
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  // ====================
  // Main sequence: one reset per strap mode
  initial begin
    {bus_select_hi, bus_select_lo, dual_pin_i, dual_func_out, eeprom_scl, eeprom_sda_drive_low} = 6'h0;
    {eeprom_absent, slave_sda_drive_low, spi_dout, addr_valid, frame, addr_byte} = 13'h0;
    {srst, serial_chip_select_n} = 2'h3;
    seed = $urandom(32'h679f);
    for (m = 3'h0; m < 3'h4; m = m + 3'h1) begin
      dexp = $urandom;
      @(posedge clk);
      {srst, bus_select_hi, bus_select_lo, dual_pin_i} <= {1'b1, m[1:0], dexp};
      tick(8);
      srst <= 1'b0;
      tick(6);
      {bus_select_hi, bus_select_lo, dual_pin_i} <= {~m[1:0], ~dexp};
      tick(10);
      #1;
      chk(mode, m[1:0]);
      chk(full_register_mgmt_access, m == 3'h3);
      chk(phy_only_mgmt_access, m != 3'h3);
      chk(scl_oe, m == 3'h0);
      chk({dual_pin_oe, dual_strap}, {1'b1, dexp});
      chk(serial_clk_in, 1'b1);
      chk(sda_o, 1'b0);
      for (i = 0; i < 8; i = i + 1) begin
        @(posedge clk);
        {eeprom_scl, eeprom_sda_drive_low, eeprom_absent, slave_sda_drive_low, spi_dout, dual_func_out} <= $urandom;
        addr_byte <= i < 3 ? 8'hbf - i : $urandom;
        {addr_valid, serial_chip_select_n, frame} <= 3'h5;
        base = hits;
        @(posedge clk);
        addr_valid <= 1'b0;
        tick(4);
        #1;
        chk(sda_oe, f_sda(m[1:0], eeprom_sda_drive_low, slave_sda_drive_low));
        chk(use_reset_defaults, m == 3'h0 && eeprom_absent);
        chk(dual_pin_o, dual_func_out);
        chk(serial_data_out_oe, m == 3'h2);
        if (m == 3'h0) chk(scl_o, eeprom_scl);
        if (m == 3'h2) chk({serial_data_out, serial_data_in}, {spi_dout, sda_i});
        chk(spi_active, m == 3'h2);
        @(posedge clk);
        {serial_chip_select_n, frame} <= 2'h2;
        tick(4);
        #1;
        chk(serial_data_out_oe, 1'b0);
        chk(spi_active, 1'b0);
        chk(8'(hits - base), f_hits(m[1:0], addr_byte));
      end
      $display("mode %0d done", m);
    end
    finish_test;
  end
endmodule
